/* File: common/supervisor_defs.svh */
// timing, register map and field constants for the reset supervisor
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define SUP_CLK_MHZ          125
`define SUP_TOUT_LONG_MS     1600
`define SUP_DELAY_LONG_MS    200
`define SUP_TOUT_SHORT_MS    200
`define SUP_DELAY_SHORT_MS   25
`define SUP_MS_TO_CYC(ms)    ((ms) * 1000 * `SUP_CLK_MHZ)
`define SUP_TOUT_LONG_CYC    `SUP_MS_TO_CYC(`SUP_TOUT_LONG_MS)
`define SUP_DELAY_LONG_CYC   `SUP_MS_TO_CYC(`SUP_DELAY_LONG_MS)
`define SUP_TOUT_SHORT_CYC   `SUP_MS_TO_CYC(`SUP_TOUT_SHORT_MS)
`define SUP_DELAY_SHORT_CYC  `SUP_MS_TO_CYC(`SUP_DELAY_SHORT_MS)

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define SUP_CTRL_OFS         8'h00
`define SUP_STATUS_OFS       8'h04
`define SUP_TOCNT_OFS        8'h08

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define SUP_CTRL_WDT_EN_BIT  0
`define SUP_CTRL_IMPROVE_BIT 1
`define SUP_CTRL_RESET_VAL   2'h3

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define SUP_ST_RESET_BIT     0
`define SUP_ST_SUPPLY_BIT    1
`define SUP_ST_MANUAL_BIT    2
`define SUP_ST_DELAY_BIT     3
`define SUP_ST_TOUT_BIT      4

`endif

/* File: common/supervisor_pkg.sv */
// types shared by the reset supervisor files
package supervisor_pkg;

  typedef enum logic [1:0]
  {
    SUP_HOLD,
    SUP_DELAY,
    SUP_RUN
  } sup_state_e;

endpackage

/* File: rtl/kick_edge_detect.sv */
// synchroniser and any-edge detector for the watchdog kick pin
`timescale 1ns/1ps

module kick_edge_detect
(
  // clock and reset
  input  wire logic sysClk,
  input  wire logic rstN,
  input  wire logic ce,
  // pin and result
  input  wire logic pinIn,
  output logic      edgePulse
);

  logic syncA;
  logic syncB;
  logic lastLevel;

  // syncA feeds syncB only; both edges count as a kick
  always_ff @(posedge sysClk)
  begin
    if (!rstN)
    begin
      syncA     <= 1'b0;
      syncB     <= 1'b0;
      lastLevel <= 1'b0;
      edgePulse <= 1'b0;
    end
    else if (ce)
    begin
      syncA     <= pinIn;
      syncB     <= syncA;
      lastLevel <= syncB;
      edgePulse <= syncB ^ lastLevel;
    end
  end

endmodule

/* File: rtl/supply_reset_watchdog_supervisor.sv */
// reset supervisor: supply, manual reset and watchdog with release delay
`timescale 1ns/1ps

`include "supervisor_defs.svh"

module supply_reset_watchdog_supervisor
  import supervisor_pkg::*;
#(
  parameter int unsigned TOUT_CYCLES    = `SUP_TOUT_LONG_CYC,
  parameter int unsigned DELAY_CYCLES   = `SUP_DELAY_LONG_CYC,
  parameter bit          HAS_WATCHDOG   = 1'b1,
  parameter bit          HAS_MANUAL     = 1'b1,
  parameter bit          HAS_ACTIVE_HIGH = 1'b1
)
(
  // clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // supply comparator and external pins
  input  wire logic        supplyBelowFall,
  input  wire logic        supplyAboveRise,
  input  wire logic        manual_reset_req_n,
  input  wire logic        watchdog_kick_in,
  // reset outputs
  output logic             resetOut_n,
  output logic             resetOut,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pinSyncA;
  logic [2:0] pinSyncB;
  logic       belowFall;
  logic       aboveRise;
  logic       manualLow;
  logic       kickEdge;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      // supply low, manual pin at its idle high level: no false request
      pinSyncA <= 3'h5;
      pinSyncB <= 3'h5;
    end
    else if (ce)
    begin
      pinSyncA <= {manual_reset_req_n, supplyAboveRise, supplyBelowFall};
      pinSyncB <= pinSyncA;
    end
  end

  assign belowFall = pinSyncB[0];
  assign aboveRise = pinSyncB[1];
  // omitted manual input reads as never requested
  assign manualLow = HAS_MANUAL ? ~pinSyncB[2] : 1'b0;

  kick_edge_detect kickDet
  (
    .sysClk    (sys_clk),
    .rstN      (rst_n),
    .ce        (ce),
    .pinIn     (watchdog_kick_in),
    .edgePulse (kickEdge)
  );

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic        wdtEnable;
  logic        improvedMode;
  logic        dataPhase;
  logic        dataWrite;
  logic [7:0]  dataAddr;
  logic        addrTaken;
  logic [31:0] timeoutCount;

  assign addrTaken = hsel & htrans[1] & hready & ce;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wdtEnable    <= 1'((`SUP_CTRL_RESET_VAL >> `SUP_CTRL_WDT_EN_BIT)
                         & 2'h1);
      improvedMode <= 1'((`SUP_CTRL_RESET_VAL >> `SUP_CTRL_IMPROVE_BIT)
                         & 2'h1);
    end
    else if (ce && dataPhase && dataWrite && dataAddr == `SUP_CTRL_OFS)
    begin
      wdtEnable    <= hwdata[`SUP_CTRL_WDT_EN_BIT];
      improvedMode <= hwdata[`SUP_CTRL_IMPROVE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // supply tracking with hysteresis
  // ----------------------------------------------------------------
  logic supplyGood;

  // good only above the rising level, lost below the falling level
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      supplyGood <= 1'b0;
    else if (ce)
    begin
      if (belowFall)
        supplyGood <= 1'b0;
      else if (aboveRise)
        supplyGood <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------
  sup_state_e  state;
  sup_state_e  next_state;
  logic [31:0] delayCnt;
  logic [31:0] wdtCnt;
  logic        holdCause;
  logic        delayDone;
  logic        wdtActive;
  logic        wdtExpire;
  logic        legacyKick;

  // supply drop or manual request hold reset with no timer running
  assign holdCause = ~supplyGood | belowFall | manualLow;
  assign delayDone = delayCnt == DELAY_CYCLES - 1;
  assign wdtActive = HAS_WATCHDOG & wdtEnable;
  assign wdtExpire = wdtActive & (wdtCnt == TOUT_CYCLES - 1);
  // without the improved mode a kick during reset restarts the delay,
  // so a busy kick line can keep reset stuck asserted
  assign legacyKick = HAS_WATCHDOG & ~improvedMode & kickEdge;

  always_comb
  begin
    next_state = state;
    case (state)
      SUP_HOLD:
        if (!holdCause)
          next_state = SUP_DELAY;
      SUP_DELAY:
        if (holdCause)
          next_state = SUP_HOLD;
        else if (delayDone && !legacyKick)
          next_state = SUP_RUN;
      SUP_RUN:
        if (holdCause)
          next_state = SUP_HOLD;
        else if (wdtExpire && !kickEdge)
          next_state = SUP_DELAY;
      default:
        next_state = SUP_HOLD;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      state <= SUP_HOLD;
    else if (ce)
      state <= next_state;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      delayCnt <= 32'h0;
    else if (ce)
    begin
      if (state != SUP_DELAY || next_state != SUP_DELAY || legacyKick)
        delayCnt <= 32'h0;
      else
        delayCnt <= delayCnt + 32'h1;
    end
  end

  // watchdog runs only while reset is released
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      wdtCnt <= 32'h0;
    else if (ce)
    begin
      if (state != SUP_RUN || kickEdge || !wdtActive || wdtExpire)
        wdtCnt <= 32'h0;
      else
        wdtCnt <= wdtCnt + 32'h1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      timeoutCount <= 32'h0;
    else if (ce && state == SUP_RUN && next_state == SUP_DELAY)
      timeoutCount <= timeoutCount + 32'h1;
  end

  // ----------------------------------------------------------------
  // reset outputs
  // ----------------------------------------------------------------
  // both outputs follow one registered decision outside reset, which loads both low
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      resetOut_n <= 1'b0;
      resetOut   <= 1'b0;
    end
    else if (ce)
    begin
      resetOut_n <= next_state == SUP_RUN;
      resetOut   <= HAS_ACTIVE_HIGH & (next_state != SUP_RUN);
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  logic [31:0] next_hrdata;

  always_comb
  begin
    next_hrdata = 32'h0;
    case (haddr[7:0])
      `SUP_CTRL_OFS:
      begin
        next_hrdata[`SUP_CTRL_WDT_EN_BIT]  = wdtEnable;
        next_hrdata[`SUP_CTRL_IMPROVE_BIT] = improvedMode;
      end
      `SUP_STATUS_OFS:
      begin
        next_hrdata[`SUP_ST_RESET_BIT]  = state != SUP_RUN;
        next_hrdata[`SUP_ST_SUPPLY_BIT] = supplyGood;
        next_hrdata[`SUP_ST_MANUAL_BIT] = manualLow;
        next_hrdata[`SUP_ST_DELAY_BIT]  = state == SUP_DELAY;
        next_hrdata[`SUP_ST_TOUT_BIT]   = timeoutCount != 32'h0;
      end
      `SUP_TOCNT_OFS:
        next_hrdata = timeoutCount;
      default:
        next_hrdata = 32'h0;
    endcase
    if (|haddr[31:8])
      next_hrdata = 32'h0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      dataPhase <= 1'b0;
      dataWrite <= 1'b0;
      dataAddr  <= 8'h0;
      hrdata    <= 32'h0;
    end
    else if (ce && hready)
    begin
      dataPhase <= addrTaken;
      dataWrite <= addrTaken & hwrite;
      dataAddr  <= (|haddr[31:8]) ? 8'hff : haddr[7:0];
      if (addrTaken && !hwrite)
        hrdata <= next_hrdata;
    end
  end

  // a frozen block stalls the bus rather than losing a transfer
  assign hreadyout = ce;
  assign hresp     = 1'b0;

endmodule

/* File: test/supervisor_assertions.sv */
// pin-level assertions for the reset supervisor
`timescale 1ns/1ps

module supervisor_assertions
#(
  parameter int unsigned TOUT_CYCLES  = 40,
  parameter int unsigned DELAY_CYCLES = 10
)
(
  // clock
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // pins
  input wire logic supplyBelowFall,
  input wire logic supplyAboveRise,
  input wire logic manual_reset_req_n,
  input wire logic watchdog_kick_in,
  input wire logic resetOut_n,
  input wire logic resetOut,
  // bus
  input wire logic hreadyout,
  input wire logic hresp
);
  logic [15:0] goodCnt;
  logic [15:0] wdCnt;
  logic        lastKick;

  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // saturates, so a long good spell never wraps back to zero
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || supplyBelowFall || !supplyAboveRise || !manual_reset_req_n)
      goodCnt <= 16'h0;
    else if (goodCnt != 16'hffff)
      goodCnt <= goodCnt + 16'h1;
  end

  // cycles spent released without any kick edge
  always_ff @(posedge sys_clk)
  begin
    lastKick <= watchdog_kick_in;
    if (!rst_n || !resetOut_n || watchdog_kick_in != lastKick)
      wdCnt <= 16'h0;
    else if (wdCnt != 16'hffff)
      wdCnt <= wdCnt + 16'h1;
  end

  sequence s_low;
    (supplyBelowFall && ce)[*8];
  endsequence
  sequence s_man;
    (!manual_reset_req_n && ce)[*8];
  endsequence

  property p_pwr_on;
    $rose(rst_n) |-> !resetOut_n && !resetOut;
  endproperty
  property p_low;
    s_low |-> !resetOut_n;
  endproperty
  property p_high;
    s_low |-> resetOut;
  endproperty
  property p_man;
    s_man |-> !resetOut_n && resetOut;
  endproperty
  property p_rel;
    $rose(resetOut_n) |-> 32'(goodCnt) >= DELAY_CYCLES;
  endproperty
  property p_drop;
    $rose(supplyBelowFall) && ce |-> ##[1:8] !resetOut_n;
  endproperty
  property p_wdog;
    32'(wdCnt) <= TOUT_CYCLES + 8;
  endproperty
  property p_ready;
    hreadyout == ce;
  endproperty
  property p_okay;
    !hresp;
  endproperty

  a_pwr_on: assert property (p_pwr_on)
    else $error("reset not held after start");
  a_low: assert property (p_low)
    else $error("low output released while supply low");
  a_high: assert property (p_high)
    else $error("high output released while supply low");
  a_man: assert property (p_man)
    else $error("manual request did not assert reset");
  a_rel: assert property (p_rel)
    else $error("reset released before delay");
  a_drop: assert property (p_drop)
    else $error("supply drop did not reassert reset");
  a_wdog: assert property (p_wdog)
    else $error("watchdog timeout missed");
  a_ready: assert property (p_ready)
    else $error("ready does not follow enable");
  a_okay: assert property (p_okay)
    else $error("error response seen");
endmodule

bind supply_reset_watchdog_supervisor supervisor_assertions
#(
  .TOUT_CYCLES(TOUT_CYCLES),
  .DELAY_CYCLES(DELAY_CYCLES)
)
i_chk
(
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .ce(ce),
  .supplyBelowFall(supplyBelowFall),
  .supplyAboveRise(supplyAboveRise),
  .manual_reset_req_n(manual_reset_req_n),
  .watchdog_kick_in(watchdog_kick_in),
  .resetOut_n(resetOut_n),
  .resetOut(resetOut),
  .hreadyout(hreadyout),
  .hresp(hresp)
);

/* File: test/proc_model.sv */
// supervised processor model: toggles the watchdog kick pin
`timescale 1ns/1ps

module proc_model
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetOut_n,
  // behaviour
  input  wire logic [7:0] period,
  input  wire logic       kickInRst,
  // kick pin
  output logic            kick
);
  logic [7:0] cnt;

  initial
  begin
    kick = 1'b0;
    cnt = 8'h0;
  end

  // a held processor stops kicking unless told to misbehave
  always @(posedge sys_clk)
  begin
    if (resetOut_n || kickInRst)
    begin
      cnt <= (cnt >= period) ? 8'h0 : cnt + 8'h1;
      if (cnt >= period)
        kick <= ~kick;
    end
  end
endmodule

/* File: test/tb.sv */
// self-checking bench for the reset supervisor
`timescale 1ns/1ps
`include "supervisor_defs.svh"

module tb;
  localparam int TOUT = 40;
  localparam int DELAY = 10;
  logic sys_clk, rst_n, below, above, mrN, kick, kickInRst, lastK;
  logic hsel, hwrite, hready, hresp, resetOut_n, resetOut;
  logic [7:0] period;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int fails, cmp_count, seed, n, kind, w;

  supply_reset_watchdog_supervisor #(.TOUT_CYCLES(TOUT), .DELAY_CYCLES(DELAY))
  i_dut
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1),
    .supplyBelowFall(below), .supplyAboveRise(above),
    .manual_reset_req_n(mrN), .watchdog_kick_in(kick),
    .resetOut_n(resetOut_n), .resetOut(resetOut),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp)
  );

  proc_model i_proc
  (
    .sys_clk(sys_clk), .resetOut_n(resetOut_n), .period(period),
    .kickInRst(kickInRst), .kick(kick)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ----
  // tasks
  // ----
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task hold;
    int i;
    i = 0;
    do @(posedge sys_clk); while (hready !== 1'b1 && ++i < 50);
    if (i >= 50)
    begin
      fails++;
      final_report;
    end
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hold();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    hold();
    rd = hrdata;
  endtask

  // cycles until the low output shows the given level
  task meas(input logic lvl);
    n = 0;
    while (resetOut_n !== lvl && n < 999)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 999)
    begin
      fails++;
      final_report;
    end
  endtask

  function logic win(int v, int lo);
    return v >= lo && v <= lo + 8;
  endfunction

  // ----
  // sequence
  // ----
  initial
  begin
    seed = 24291;
    fails = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    below = 1'b1;
    above = 1'b0;
    mrN = 1'b1;
    kickInRst = 1'b0;
    period = 8'h13;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk(resetOut_n, 32'h0);
    ahb(1'b0, `SUP_CTRL_OFS, 32'h0);
    chk(rd, `SUP_CTRL_RESET_VAL);
    ahb(1'b0, `SUP_STATUS_OFS, 32'h0);
    chk(rd & 32'h1f, 32'h1);
    ahb(1'b1, `SUP_CTRL_OFS, 32'h1);
    ahb(1'b0, `SUP_CTRL_OFS, 32'h0);
    chk(rd, 32'h1);
    ahb(1'b1, `SUP_CTRL_OFS, 32'h3);
    ahb(1'b1, 8'h0c, 32'hffff);
    ahb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    $display("test registers done");
    below <= 1'b0;
    above <= 1'b1;
    meas(1'b1);
    chk(win(n, DELAY), 32'h1);
    repeat (10)
    begin
      kind = $random(seed) & 1;
      kickInRst <= 1'($random(seed));
      if (kind == 1)
        mrN <= 1'b0;
      else
      begin
        below <= 1'b1;
        above <= 1'b0;
      end
      repeat (8 + ($random(seed) & 7)) @(posedge sys_clk);
      chk({resetOut_n, resetOut}, 32'h1);
      mrN <= 1'b1;
      below <= 1'b0;
      if (kind == 0)
      begin
        repeat (2 * DELAY) @(posedge sys_clk);
        chk(resetOut_n, 32'h0);
        above <= 1'b1;
      end
      if ($random(seed) & 1)
      begin
        repeat (DELAY - 2) @(posedge sys_clk);
        below <= 1'b1;
        above <= 1'b0;
        @(posedge sys_clk);
        below <= 1'b0;
        above <= 1'b1;
      end
      meas(1'b1);
      chk(win(n, DELAY), 32'h1);
    end
    $display("test release done");
    // time the timeout from a known kick edge, not a random phase
    w = 0;
    lastK = kick;
    do @(posedge sys_clk); while (kick === lastK && ++w < 99);
    if (w >= 99)
    begin
      fails++;
      final_report;
    end
    period <= 8'h3b;
    meas(1'b0);
    chk(win(n, TOUT - 2), 32'h1);
    meas(1'b1);
    chk(win(n, DELAY - 2), 32'h1);
    period <= 8'h13;
    repeat (5 * TOUT)
    begin
      @(posedge sys_clk);
      chk(resetOut_n, 32'h1);
    end
    ahb(1'b0, `SUP_STATUS_OFS, 32'h0);
    chk(rd & 32'h1f, 32'h12);
    ahb(1'b0, `SUP_TOCNT_OFS, 32'h0);
    chk(rd, 32'h1);
    $display("test watchdog done");
    final_report;
  end
endmodule
